// ==== verif/timer_control_event_regs_props.sv ====
`timescale 1ns/1ns
// ==========================================================================
// Bus handshake and output checks
// ==========================================================================
module timer_control_event_regs_props (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire timer_ctrl_pkg::bus_req_t busReq,
  input wire timer_ctrl_pkg::bus_rsp_t busRsp,
  input wire logic                     eventIn,
  input wire logic                     countTick,
  input wire logic [2:0]               padOut,
  input wire logic [2:0]               cellOut,
  input wire logic                     splitSelect,
  input wire logic                     countDown,
  input wire logic                     restartPulse,
  input wire logic                     hardResetPulse,
  input wire logic                     updatePulse
);
  logic [7:0] arAddr_r;

  // The read address is kept so that read data can be judged by register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) arAddr_r <= 8'h00;
    else if (busReq.arvalid && busRsp.arready) arAddr_r <= busReq.araddr;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wrTaken;
    busReq.awvalid && busRsp.awready && busReq.wvalid && busRsp.wready;
  endsequence
  sequence s_rdTaken;
    busReq.arvalid && busRsp.arready;
  endsequence

  property p_wrAnswer; s_wrTaken |-> ##[1:2] busRsp.bvalid; endproperty
  property p_rdAnswer; s_rdTaken |-> ##[1:2] busRsp.rvalid; endproperty
  property p_bHold;
    busRsp.bvalid && !busReq.bready |=> busRsp.bvalid && $stable(busRsp.bresp);
  endproperty
  property p_rHold;
    busRsp.rvalid && !busReq.rready |=> busRsp.rvalid && $stable(busRsp.rdata);
  endproperty
  property p_wrBlock; busRsp.bvalid |-> !busRsp.awready && !busRsp.wready; endproperty
  property p_badRead;
    s_rdTaken ##0 busReq.araddr == 8'h40 |-> ##[1:2] (busRsp.rvalid && busRsp.rresp == 2'h2);
  endproperty
  property p_cmdZero;
    busRsp.rvalid && (arAddr_r == 8'h10 || arAddr_r == 8'h14) |-> busRsp.rdata[3:2] == 2'h0;
  endproperty
  property p_padGate; (padOut & ~cellOut) == 3'h0; endproperty

  a_wrAnswer: assert property (p_wrAnswer) else $error("write response missing");
  a_rdAnswer: assert property (p_rdAnswer) else $error("read response missing");
  a_bHold: assert property (p_bHold) else $error("write response dropped early");
  a_rHold: assert property (p_rHold) else $error("read data dropped early");
  a_wrBlock: assert property (p_wrBlock) else $error("write accepted during response");
  a_badRead: assert property (p_badRead) else $error("unmapped read not refused");
  a_cmdZero: assert property (p_cmdZero) else $error("command field read nonzero");
  a_padGate: assert property (p_padGate) else $error("pad level without cell level");
endmodule

// ==== verif/timer_control_event_regs_tb_top.sv ====
`timescale 1ns/1ns
module timer_control_event_regs_tb_top;
  logic                     sys_clk;
  logic                     rst_n;
  timer_ctrl_pkg::bus_req_t busReq;
  timer_ctrl_pkg::bus_rsp_t busRsp;
  logic                     eventIn;
  logic                     countTick;
  logic [2:0]               padOut;
  logic [2:0]               cellOut;
  logic                     splitSelect;
  logic                     countDown;
  logic                     restartPulse;
  logic                     hardResetPulse;
  logic                     updatePulse;
  int                       errCount;
  int                       samplesChecked;
  int                       pulseCnt [3];
  logic [31:0]              rdData;
  logic [1:0]               rdResp;
  logic [1:0]               wrResp;
  logic [7:0]               rstAddr [9] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24,
                                            8'h98, 8'hD8};
  logic [31:0]              rstVal [9] = '{0, 0, 0, 0, 0, 0, 0, 32'h0000FFFF, 32'h0000FFFF};
  logic [31:0]              evSel [7] = '{32'h1, 32'h3, 32'h5, 32'h7, 32'h9, 32'hF, 32'h2};
  logic [31:0]              evExp [7] = '{32'h12, 32'h13, 32'h13, 32'h0D, 32'h10, 32'h10,
                                          32'h13};

  timer_control_event_regs u_timer_control_event_regs (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .busReq        (busReq),
    .busRsp        (busRsp),
    .eventIn       (eventIn),
    .countTick     (countTick),
    .padOut        (padOut),
    .cellOut       (cellOut),
    .splitSelect   (splitSelect),
    .countDown     (countDown),
    .restartPulse  (restartPulse),
    .hardResetPulse(hardResetPulse),
    .updatePulse   (updatePulse)
  );

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (updatePulse === 1'b1) pulseCnt[0]++;
    if (restartPulse === 1'b1) pulseCnt[1]++;
    if (hardResetPulse === 1'b1) pulseCnt[2]++;
  end

  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic testDone();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 40) begin
      errCount++;
      $display("CHECK FAILED at %0t: bus wait ran out", $time);
      testDone();
    end
  endtask

  task automatic chkData(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chkPin(input logic [2:0] got, input logic [2:0] exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awOpen;
    logic wOpen;
    int   n;
    awOpen = 1'b1;
    wOpen = 1'b1;
    n = 0;
    @(posedge sys_clk);
    busReq.awvalid <= 1'b1;
    busReq.awaddr <= a;
    busReq.wvalid <= 1'b1;
    busReq.wdata <= d;
    busReq.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awOpen && busRsp.awready === 1'b1) begin
        awOpen = 1'b0;
        busReq.awvalid <= 1'b0;
      end
      if (wOpen && busRsp.wready === 1'b1) begin
        wOpen = 1'b0;
        busReq.wvalid <= 1'b0;
      end
    end while (busRsp.bvalid !== 1'b1 && n < 40);
    wrResp = busRsp.bresp;
    busReq.bready <= 1'b0;
    guard(n);
    // Outputs derived from the written register are registered one edge later.
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    busReq.arvalid <= 1'b1;
    busReq.araddr <= a;
    busReq.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (busRsp.arready === 1'b1) busReq.arvalid <= 1'b0;
    end while (busRsp.rvalid !== 1'b1 && n < 40);
    rdData = busRsp.rdata;
    rdResp = busRsp.rresp;
    busReq.rready <= 1'b0;
    guard(n);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chkData(rdData, exp, $sformatf("read %h", a));
  endtask

  // Three edges first (rise, fall, rise), then three prescaled ticks while the event is high.
  task automatic evPhase();
    @(posedge sys_clk) eventIn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    eventIn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    eventIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    repeat (3) begin
      countTick <= 1'b1;
      @(posedge sys_clk) countTick <= 1'b0;
      @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    errCount = 0;
    samplesChecked = 0;
    busReq = '0;
    busReq.wstrb = 4'hF;
    eventIn = 1'b0;
    countTick = 1'b0;
    rst_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rdChk(rstAddr[i], rstVal[i]);
    rd(8'h40);
    chkData({30'h0, rdResp}, 32'h2, "unmapped read response");
    wr(8'h40, 32'hFF);
    chkData({30'h0, wrResp}, 32'h2, "unmapped write response");
    $display("Test reset and map done");
    wr(8'h08, 32'h5);
    chkPin(cellOut, 3'h5, "cell levels");
    chkPin(padOut, 3'h0, "pad levels gated");
    wr(8'h04, 32'h30);
    chkPin(padOut, 3'h1, "pad levels enabled");
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h2);
    wr(8'h00, 32'h0);
    rdChk(8'h08, 32'h5);
    wr(8'h0C, 32'h1);
    chkPin({2'h0, splitSelect}, 3'h1, "split select");
    wr(8'h0C, 32'h0);
    $display("Test forced levels and split done");
    wr(8'h14, 32'h3);
    rdChk(8'h10, 32'h3);
    chkPin({2'h0, countDown}, 3'h1, "direction down");
    wr(8'h10, 32'h1);
    rdChk(8'h14, 32'h2);
    chkPin({2'h0, countDown}, 3'h0, "direction up");
    wr(8'h10, 32'h2);
    rdChk(8'h14, 32'h0);
    for (int v = 0; v < 2; v++) begin
      for (int c = 1; c < 4; c++) wr(v ? 8'h14 : 8'h10, 32'(c) << 2);
    end
    rdChk(8'h14, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h14, 32'hC);
    wr(8'h00, 32'h0);
    chkData(pulseCnt[0], 2, "update pulses");
    chkData(pulseCnt[1], 2, "restart pulses");
    chkData(pulseCnt[2], 2, "hard reset pulses");
    $display("Test direction and commands done");
    for (int i = 0; i < 7; i++) begin
      wr(8'h24, evSel[i]);
      wr(8'h10, 32'h1);
      wr(8'h80, 32'h10);
      wr(8'h00, 32'h1);
      evPhase();
      wr(8'h00, 32'h0);
      eventIn <= 1'b0;
      rdChk(8'h80, evExp[i]);
      chkPin({2'h0, countDown}, (i == 3) ? 3'h1 : 3'h0, "event direction");
    end
    $display("Test event actions done");
    wr(8'hD8, 32'h3);
    wr(8'hE0, 32'h11);
    wr(8'hE8, 32'h12);
    wr(8'hF0, 32'h13);
    rdChk(8'h18, 32'hF);
    wr(8'h18, 32'h2);
    rdChk(8'h1C, 32'hD);
    wr(8'h1C, 32'h2);
    rdChk(8'h18, 32'hF);
    wr(8'h14, 32'h2);
    wr(8'h14, 32'h4);
    rdChk(8'h18, 32'h0);
    rdChk(8'hA0, 32'h11);
    rdChk(8'h98, 32'h3);
    wr(8'hE0, 32'h22);
    wr(8'h80, 32'h0);
    countTick <= 1'b1;
    wr(8'h00, 32'h1);
    repeat (20) @(posedge sys_clk);
    rdChk(8'hA0, 32'h11);
    wr(8'h10, 32'h2);
    repeat (20) @(posedge sys_clk);
    wr(8'h00, 32'h0);
    countTick <= 1'b0;
    rdChk(8'hA0, 32'h22);
    rdChk(8'h18, 32'h0);
    wr(8'h04, 32'h78);
    rdChk(8'h14, 32'h2);
    wr(8'hE0, 32'h1);
    wr(8'hE8, 32'h2);
    wr(8'hF0, 32'h3);
    rdChk(8'h14, 32'h0);
    $display("Test buffers and lock done");
    testDone();
  end
endmodule

bind timer_control_event_regs timer_control_event_regs_props u_timer_control_event_regs_props (
  .sys_clk       (sys_clk),
  .rst_n         (rst_n),
  .busReq        (busReq),
  .busRsp        (busRsp),
  .eventIn       (eventIn),
  .countTick     (countTick),
  .padOut        (padOut),
  .cellOut       (cellOut),
  .splitSelect   (splitSelect),
  .countDown     (countDown),
  .restartPulse  (restartPulse),
  .hardResetPulse(hardResetPulse),
  .updatePulse   (updatePulse)
);

// ==== verilog/timer_control_event_regs.sv ====
//
// Behaviour
// - While stopped, software forces each of three waveform output levels.
// - Pad output needs its enable bit; logic-cell output bypasses the enable.
// - Split bit selects two independent 8-bit counters; here it only drives splitSelect, the count stays one 16-bit counter.
// - Command field bits 3:2 decode none, update, restart, hard reset.
// - Hard reset command is ignored while the counter runs.
// - Command field always reads zero in both views.
// - Lock-update set blocks buffer transfer on hardware update condition.
// - Software update command transfers buffers even when locked.
// - Lock-update clear lets every update condition transfer buffers.
// - Direction at bit 0 (1 = down), lock-update at bit 1.
// - Hardware drives direction, software may also write it.
// - Writing 1 in a clear view clears the bit; 0 leaves it.
// - Writing 1 in a set view sets the bit; both views read alike.
// - Writing a compare buffer sets its buffer-valid flag.
// - Update clears all compare buffer-valid flags.
// - Period buffer write sets its flag; update clears it.
// - Flags: period at bit 0, compare 0..2 at bits 1..3.
// - Action 0 counts rising edges, action 1 counts both edges.
// - Action 2 counts prescaled clocks while event is high.
// - Action 3 counts prescaled clocks, event level latches direction.
// - Event enable bit 0 off disables; on applies action field bits 3:1.
// - Auto-lock holds lock until enabled flags valid, sets again after update.
// - Update loads each compare register from its buffer.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "timer_ctrl_consts.svh"

module timer_control_event_regs (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire timer_ctrl_pkg::bus_req_t  busReq,
  output      timer_ctrl_pkg::bus_rsp_t  busRsp,
  input  wire logic                      eventIn,
  input  wire logic                      countTick,
  output      logic [2:0]                padOut,
  output      logic [2:0]                cellOut,
  output      logic                      splitSelect,
  output      logic                      countDown,
  output      logic                      restartPulse,
  output      logic                      hardResetPulse,
  output      logic                      updatePulse
);

  // ========================================================================
  // State
  // ========================================================================
  timer_ctrl_pkg::state_t state_r;
  timer_ctrl_pkg::state_t state_nxt;

  logic [7:0]  wIdx;
  logic [7:0]  rIdx;
  logic        doWrite;
  logic        doRead;
  logic [7:0]  wByte;
  logic [15:0] wHalf;
  logic [7:0]  rByte;
  logic [15:0] rHalf;
  logic        rHit;
  logic        wHit;
  logic        countStep;
  logic        stepDown;
  logic        hwUpdate;
  logic        anyUpdate;
  logic        atTop;
  logic        atBottom;
  logic [2:0]  waveLevel;
  logic [2:0]  cmpEnabledValid;
  logic [3:0]  bufSet;

  assign busRsp         = state_r.rsp;
  assign padOut         = state_r.padOut;
  assign cellOut        = state_r.cellOut;
  assign splitSelect    = state_r.splitSelect;
  assign countDown      = state_r.dir;
  assign restartPulse   = state_r.restartPulse;
  assign hardResetPulse = state_r.hardResetPulse;
  assign updatePulse    = state_r.updatePulse;

  always_comb begin
    wIdx  = {2'h0, state_r.awAddr[7:2]};
    rIdx  = {2'h0, busReq.araddr[7:2]};
    wByte = state_r.wData[7:0];
    wHalf = state_r.wData[15:0];
    // Only the second byte lane matters beyond the first, for the 16-bit buffers and the count.
    doWrite = state_r.awHeld && state_r.wHeld && !state_r.rsp.bvalid;
    doRead  = busReq.arvalid && state_r.rsp.arready;
  end

  // ========================================================================
  // Counting and update conditions
  // ========================================================================
  always_comb begin
    atTop    = state_r.count == state_r.period;
    atBottom = state_r.count == `RST_WORD;
    countStep = 1'b0;
    stepDown  = state_r.dir;
    if (!state_r.evEnable) begin
      countStep = countTick;
    end else begin
      case (state_r.evAction)
        timer_ctrl_pkg::EV_RISING: countStep = state_r.evSync2 && !state_r.evPrev;
        timer_ctrl_pkg::EV_BOTH:   countStep = state_r.evSync2 != state_r.evPrev;
        timer_ctrl_pkg::EV_HIGH:   countStep = countTick && state_r.evSync2;
        timer_ctrl_pkg::EV_UPDOWN: begin
          countStep = countTick;
          stepDown  = state_r.evSync2;
        end
        default:                   countStep = 1'b0;
      endcase
    end
    countStep = countStep && state_r.runEnable;
    hwUpdate  = countStep && (stepDown ? atBottom : atTop);
  end

  // ========================================================================
  // Register read mux
  // ========================================================================
  always_comb begin
    rHit  = 1'b1;
    rByte = `RST_BYTE;
    rHalf = `RST_WORD;
    case (rIdx)
      `IDX_RUN_CTRL:     rByte = {7'h00, state_r.runEnable};
      `IDX_WAVE_CTRL:    rByte = {1'b0, state_r.waveEnable, state_r.autoLock, 3'h0};
      `IDX_OUTPUT_VALUE: rByte = {5'h00, state_r.forcedValue};
      `IDX_SPLIT_SELECT: rByte = {7'h00, state_r.splitSelect};
      `IDX_CMD_DIR_CLR,
      `IDX_CMD_DIR_SET:  rByte = {6'h00, state_r.updateLock, state_r.dir};
      `IDX_BUFVALID_CLR,
      `IDX_BUFVALID_SET: rByte = {4'h0, state_r.bufValid};
      `IDX_EVENT_CTRL:   rByte = {4'h0, state_r.evAction, state_r.evEnable};
      `IDX_PERIOD_BUF:   rHalf = state_r.periodBuf;
      `IDX_CMP0_BUF:     rHalf = state_r.cmpBuf0;
      `IDX_CMP1_BUF:     rHalf = state_r.cmpBuf1;
      `IDX_CMP2_BUF:     rHalf = state_r.cmpBuf2;
      `IDX_PERIOD:       rHalf = state_r.period;
      `IDX_CMP0:         rHalf = state_r.cmp0;
      `IDX_CMP1:         rHalf = state_r.cmp1;
      `IDX_CMP2:         rHalf = state_r.cmp2;
      `IDX_COUNT:        rHalf = state_r.count;
      default:           rHit  = 1'b0;
    endcase
    wHit = 1'b1;
    case (wIdx)
      `IDX_RUN_CTRL, `IDX_WAVE_CTRL, `IDX_OUTPUT_VALUE, `IDX_SPLIT_SELECT,
      `IDX_CMD_DIR_CLR, `IDX_CMD_DIR_SET, `IDX_BUFVALID_CLR, `IDX_BUFVALID_SET,
      `IDX_EVENT_CTRL, `IDX_PERIOD_BUF, `IDX_CMP0_BUF, `IDX_CMP1_BUF,
      `IDX_CMP2_BUF, `IDX_COUNT:  wHit = 1'b1;
      default:                    wHit = 1'b0;
    endcase
  end

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    state_nxt = state_r;
    state_nxt.restartPulse   = 1'b0;
    state_nxt.hardResetPulse = 1'b0;
    state_nxt.updatePulse    = 1'b0;
    bufSet                   = 4'h0;

    // Synchroniser: the first stage feeds only the second.
    state_nxt.evSync1 = eventIn;
    state_nxt.evSync2 = state_r.evSync1;
    state_nxt.evPrev  = state_r.evSync2;

    // AXI4-Lite write address and data are taken independently.
    if (busReq.awvalid && state_r.rsp.awready) begin
      state_nxt.awHeld      = 1'b1;
      state_nxt.awAddr      = busReq.awaddr;
      state_nxt.rsp.awready = 1'b0;
    end
    if (busReq.wvalid && state_r.rsp.wready) begin
      state_nxt.wHeld      = 1'b1;
      state_nxt.wData      = busReq.wdata;
      state_nxt.wStrb      = busReq.wstrb;
      state_nxt.rsp.wready = 1'b0;
    end
    if (state_r.rsp.bvalid && busReq.bready) begin
      state_nxt.rsp.bvalid  = 1'b0;
      state_nxt.rsp.awready = 1'b1;
      state_nxt.rsp.wready  = 1'b1;
    end
    if (doRead) begin
      state_nxt.rsp.arready = 1'b0;
      state_nxt.rsp.rvalid  = 1'b1;
      state_nxt.rsp.rdata   = {16'h0000, rHalf | {8'h00, rByte}};
      state_nxt.rsp.rresp   = rHit ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (state_r.rsp.rvalid && busReq.rready) begin
      state_nxt.rsp.rvalid  = 1'b0;
      state_nxt.rsp.arready = 1'b1;
    end

    // Counter core: hardware may flip direction; here event action 3 does.
    if (countStep) begin
      if (state_r.evEnable && state_r.evAction == timer_ctrl_pkg::EV_UPDOWN) begin
        state_nxt.dir = stepDown;
      end
      if (stepDown) begin
        state_nxt.count = atBottom ? state_r.period : state_r.count - 16'h0001;
      end else begin
        state_nxt.count = atTop ? `RST_WORD : state_r.count + 16'h0001;
      end
    end

    // Split select is only held here; nothing changes the count sequence, which stays one 16-bit counter.
    state_nxt.splitSelect = state_r.splitSelect;

    anyUpdate = 1'b0;
    if (hwUpdate && !state_r.updateLock) begin
      anyUpdate = 1'b1;
    end

    if (doWrite) begin
      state_nxt.wHeld      = 1'b0;
      state_nxt.awHeld     = 1'b0;
      state_nxt.rsp.bvalid = 1'b1;
      state_nxt.rsp.bresp  = wHit ? `RESP_OKAY : `RESP_SLVERR;
      if (state_r.wStrb[0]) begin
        case (wIdx)
          `IDX_RUN_CTRL:     state_nxt.runEnable = wByte[`BIT_RUN_ENABLE];
          `IDX_WAVE_CTRL: begin
            state_nxt.waveEnable = wByte[`WAVE_EN_LSB +: 3];
            state_nxt.autoLock   = wByte[`BIT_AUTO_LOCK];
          end
          `IDX_OUTPUT_VALUE: begin
            if (!state_r.runEnable) begin
              state_nxt.forcedValue = wByte[2:0];
            end
          end
          `IDX_SPLIT_SELECT: state_nxt.splitSelect = wByte[0];
          `IDX_CMD_DIR_CLR: begin
            if (wByte[`BIT_DIR])  state_nxt.dir = 1'b0;
            if (wByte[`BIT_LOCK]) state_nxt.updateLock = 1'b0;
          end
          `IDX_CMD_DIR_SET: begin
            if (wByte[`BIT_DIR])  state_nxt.dir = 1'b1;
            if (wByte[`BIT_LOCK]) state_nxt.updateLock = 1'b1;
          end
          `IDX_BUFVALID_CLR: state_nxt.bufValid = state_r.bufValid & ~wByte[3:0];
          `IDX_BUFVALID_SET: bufSet = wByte[3:0];
          `IDX_EVENT_CTRL: begin
            state_nxt.evEnable = wByte[`BIT_EV_ENABLE];
            state_nxt.evAction = wByte[`EV_ACT_LSB +: 3];
          end
          default: ;
        endcase
        if (wIdx == `IDX_CMD_DIR_CLR || wIdx == `IDX_CMD_DIR_SET) begin
          case (timer_ctrl_pkg::command_t'(wByte[`CMD_LSB +: 2]))
            timer_ctrl_pkg::CMD_UPDATE:  anyUpdate = 1'b1;
            timer_ctrl_pkg::CMD_RESTART: begin
              state_nxt.restartPulse = 1'b1;
              state_nxt.count        = `RST_WORD;
            end
            timer_ctrl_pkg::CMD_RESET: begin
              if (!state_r.runEnable) begin
                state_nxt.hardResetPulse = 1'b1;
                state_nxt.count          = `RST_WORD;
                state_nxt.dir            = 1'b0;
                state_nxt.forcedValue    = 3'h0;
              end
            end
            default: ;
          endcase
        end
      end
      if (state_r.wStrb[1:0] != 2'h0) begin
        case (wIdx)
          `IDX_PERIOD_BUF: begin
            state_nxt.periodBuf   = wHalf;
            bufSet[0]             = 1'b1;
          end
          `IDX_CMP0_BUF: begin
            state_nxt.cmpBuf0     = wHalf;
            bufSet[1]             = 1'b1;
          end
          `IDX_CMP1_BUF: begin
            state_nxt.cmpBuf1     = wHalf;
            bufSet[2]             = 1'b1;
          end
          `IDX_CMP2_BUF: begin
            state_nxt.cmpBuf2     = wHalf;
            bufSet[3]             = 1'b1;
          end
          `IDX_COUNT:    state_nxt.count = wHalf;
          default: ;
        endcase
      end
    end

    // Software sets are merged once here so that an update below can keep them.
    state_nxt.bufValid = state_nxt.bufValid | bufSet;
    if (anyUpdate) begin
      state_nxt.updatePulse = 1'b1;
      state_nxt.period = state_r.periodBuf;
      state_nxt.cmp0   = state_r.cmpBuf0;
      state_nxt.cmp1   = state_r.cmpBuf1;
      state_nxt.cmp2   = state_r.cmpBuf2;
      // A buffer write in the same cycle keeps its flag: set beats clear.
      state_nxt.bufValid = bufSet;
    end

    // Auto-lock tracks the enabled channels only; disabled ones never block.
    cmpEnabledValid = state_r.bufValid[3:1] | ~state_r.waveEnable;
    if (state_r.autoLock) begin
      if (anyUpdate) begin
        state_nxt.updateLock = 1'b1;
      end else if (&cmpEnabledValid) begin
        state_nxt.updateLock = 1'b0;
      end else if (state_r.updateLock == 1'b0 && state_r.bufValid[3:1] == 3'h0) begin
        state_nxt.updateLock = 1'b1;
      end
    end

    // Waveform generator: compare levels while running, forced levels when stopped.
    waveLevel = state_r.runEnable ?
                {state_r.count < state_r.cmp2, state_r.count < state_r.cmp1,
                 state_r.count < state_r.cmp0} : state_r.forcedValue;
    state_nxt.padOut  = waveLevel & state_r.waveEnable;
    state_nxt.cellOut = waveLevel;
  end

  // ========================================================================
  // Registers
  // ========================================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r             <= '0;
      state_r.rsp.awready <= 1'b1;
      state_r.rsp.wready  <= 1'b1;
      state_r.rsp.arready <= 1'b1;
      state_r.periodBuf   <= `RST_PERIOD;
      state_r.period      <= `RST_PERIOD;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule

// ==== verilog/timer_ctrl_consts.svh ====
`ifndef TIMER_CTRL_CONSTS_SVH
`define TIMER_CTRL_CONSTS_SVH

// ==========================================================================
// Register byte addresses (printed offsets are indices; address = 4 * index)
// ==========================================================================
`define IDX_OUTPUT_VALUE   8'h02
`define IDX_SPLIT_SELECT   8'h03
`define IDX_CMD_DIR_CLR    8'h04
`define IDX_CMD_DIR_SET    8'h05
`define IDX_BUFVALID_CLR   8'h06
`define IDX_BUFVALID_SET   8'h07
`define IDX_EVENT_CTRL     8'h09
`define IDX_WAVE_CTRL      8'h01
`define IDX_RUN_CTRL       8'h00
`define IDX_PERIOD_BUF     8'h36
`define IDX_CMP0_BUF       8'h38
`define IDX_CMP1_BUF       8'h3A
`define IDX_CMP2_BUF       8'h3C
`define IDX_PERIOD         8'h26
`define IDX_CMP0           8'h28
`define IDX_CMP1           8'h2A
`define IDX_CMP2           8'h2C
`define IDX_COUNT          8'h20

// ==========================================================================
// Field positions
// ==========================================================================
`define BIT_DIR            0
`define BIT_LOCK           1
`define CMD_LSB            2
`define BIT_EV_ENABLE      0
`define EV_ACT_LSB         1
`define BIT_AUTO_LOCK      3
`define BIT_RUN_ENABLE     0
`define WAVE_EN_LSB        4

// ==========================================================================
// Reset values
// ==========================================================================
`define RST_BYTE           8'h00
`define RST_PERIOD         16'hFFFF
`define RST_WORD           16'h0000

// ==========================================================================
// Bus answers
// ==========================================================================
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ==== verilog/timer_ctrl_pkg.sv ====
package timer_ctrl_pkg;

  typedef enum logic [1:0] {
    CMD_NONE    = 2'h0,
    CMD_UPDATE  = 2'h1,
    CMD_RESTART = 2'h2,
    CMD_RESET   = 2'h3
  } command_t;

  typedef enum logic [2:0] {
    EV_RISING   = 3'h0,
    EV_BOTH     = 3'h1,
    EV_HIGH     = 3'h2,
    EV_UPDOWN   = 3'h3
  } event_action_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } bus_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bus_rsp_t;

  typedef struct packed {
    logic              awHeld;
    logic [7:0]        awAddr;
    logic              wHeld;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    bus_rsp_t          rsp;
    logic              runEnable;
    logic [2:0]        waveEnable;
    logic              autoLock;
    logic [2:0]        forcedValue;
    logic              splitSelect;
    logic              dir;
    logic              updateLock;
    logic [3:0]        bufValid;
    logic              evEnable;
    logic [2:0]        evAction;
    logic [15:0]       periodBuf;
    logic [15:0]       cmpBuf0;
    logic [15:0]       cmpBuf1;
    logic [15:0]       cmpBuf2;
    logic [15:0]       period;
    logic [15:0]       cmp0;
    logic [15:0]       cmp1;
    logic [15:0]       cmp2;
    logic [15:0]       count;
    logic              evSync1;
    logic              evSync2;
    logic              evPrev;
    logic              restartPulse;
    logic              hardResetPulse;
    logic              updatePulse;
    logic [2:0]        padOut;
    logic [2:0]        cellOut;
  } state_t;

endpackage
